// ==== pecr_bank.sv ====
// per-port management register bank for registers 19 to 26
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RQ1 - receive error count in 19 low byte saturates at 255, clears on read
// RQ2 - false carrier count in 20 low byte saturates at 255, clears on read
// RQ3 - copper link disconnect count in 21 saturates at 255, clears on read
// RQ4 - force-link-high skips link integrity and reports link pass
// RQ5 - sticky-reset enable set keeps sticky bits over software reset; default one
// RQ6 - sticky-reset enable clear returns sticky bits to defaults on software reset
// RQ7 - super-sticky bits, sticky enable included, survive every software reset
// RQ8 - end-of-frame error and tenbase disconnect flags latch, clear on read
// RQ9 - broadcast write set applies any write to every port's register
// RQ10 - reads under broadcast return only the addressed port's value
// RQ11 - mac mode bit picks SGMII at zero, 1000BASE-X at one
// RQ12 - three-bit media mode decodes copper, fibre, FX, auto sense, reserved
// RQ13 - override field: normal, serdes only, copper only, reserved
// RQ14 - mode bits of register 23 take effect only after software reset
// RQ15 - reads of mode bits show the mode in force, not the pending one
// RQ16 - far-end loopback bit enables far-end loopback, resets disabled
// RQ17 - jumbo field sets maximum packet length 1.5, 9 or 12 kB
// RQ18 - bit 0 of register 24 enables connector loopback, reset disabled
// RQ19 - interrupt pin enable gates the interrupt pin, never asserts when clear
// RQ20 - enabled pin follows the top pending bit of register 26
// RQ21 - clearing pin enable only stops the pin; status keeps latching
// RQ22 - software reads register 26 before enabling the pin
// RQ23 - a read of register 26 clears every set bit
// RQ24 - top pending bit sets when any masked status bit becomes pending
module pecr_bank
(
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        softReset,
  input  wire pecr_pkg::pecr_mgmt_req_type mgmtReq,
  input  wire pecr_pkg::pecr_line_evt_type lineEvt,
  output logic [15:0]                      readData,
  output logic                             readValid,
  output pecr_pkg::pecr_ctrl_type          ctrl,
  output pecr_pkg::pecr_media_type         media,
  output logic                             tenLinkPass,
  output logic [13:0]                      maxFrameBytes,
  output logic                             mgmtIrqPinOut,
  output logic                             mgmtIrqPinOe
);

  // decoding helpers
  function automatic logic [7:0] satInc(input logic [7:0] cnt, input logic evt);
    satInc = (evt && cnt != pecr_pkg::COUNT_MAX) ? cnt + 8'h01 : cnt;
  endfunction : satInc

  function automatic pecr_pkg::pecr_media_type decodeMedia(input logic [2:0] mode,
                                                           input logic [1:0] ovr);
    pecr_pkg::pecr_media_type m;
    m = '0;
    unique case (mode)
      3'h0: m.copperAllowed = 1'b1;
      3'h1, 3'h2, 3'h3: m.serdesAllowed = 1'b1;
      3'h4: m.modeReserved = 1'b1;
      default:
      begin
        m.copperAllowed = 1'b1;
        m.serdesAllowed = 1'b1;
        m.autoMediaSelect = 1'b1;
      end
    endcase
    // override narrows auto sense to one medium
    if (m.autoMediaSelect && ovr == 2'h1)
    begin
      m.copperAllowed = 1'b0;
    end
    else if (m.autoMediaSelect && ovr == 2'h2)
    begin
      m.serdesAllowed = 1'b0;
    end
    decodeMedia = m;
  endfunction : decodeMedia

  function automatic logic [13:0] jumboLimit(input logic [1:0] sel);
    unique case (pecr_pkg::pecr_jumbo_type'(sel))
      pecr_pkg::JUMBO_9K:  jumboLimit = pecr_pkg::FRAME_JUMBO_9K;
      pecr_pkg::JUMBO_12K: jumboLimit = pecr_pkg::FRAME_JUMBO_12K;
      default:             jumboLimit = pecr_pkg::FRAME_NORMAL;
    endcase
  endfunction : jumboLimit

  logic [7:0]  count_q [pecr_pkg::NUM_COUNTERS];
  logic [pecr_pkg::NUM_COUNTERS-1:0] countEvt;
  logic [15:0] tenCtrl_q;
  logic        stickyEn_q;
  logic        eofErr_q;
  logic        tenDisc_q;
  logic [15:0] mediaHold_q;
  logic [5:0]  modeActive_q;
  localparam int MODE_BASE = pecr_pkg::MEDIA_MODE_LSB; // bit 0 of the active mode copy
  logic [15:0] mediaPlain_q;
  logic [15:0] edgeSticky_q;
  logic [15:0] edgePlain_q;
  logic [15:0] irqMask_q;
  logic [14:0] irqCause_q;
  logic        irqTop_q;
  logic [15:0] readData_q;
  logic        readValid_q;
  logic [15:0] readData_d;
  logic        wrEn;
  logic        rdEn;
  logic        stickyClear;
  logic [14:0] causeIn;

  // a write lands here when addressed or when broadcast is on
  assign wrEn = mgmtReq.write &&
                (mgmtReq.addressedHere || tenCtrl_q[pecr_pkg::BROADCAST_BIT]); // RQ9
  // reads, and their clearing side effects, belong to the addressed port only
  assign rdEn = mgmtReq.read && mgmtReq.addressedHere; // RQ10
  assign stickyClear = softReset && !stickyEn_q; // RQ6
  assign countEvt = {lineEvt.linkDisconnect, lineEvt.falseCarrier, lineEvt.rxError};
  assign causeIn = lineEvt.irqCause & pecr_pkg::IRQ_CAUSE_MASK;

  // saturating clear-on-read error counters, an event in the read cycle is kept
  for (genvar i = 0; i < pecr_pkg::NUM_COUNTERS; i++)
  begin : gCount
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
        count_q[i] <= 8'h00;
      else if (softReset)
        count_q[i] <= 8'h00;
      else if (rdEn && mgmtReq.addr == pecr_pkg::ADDR_RX_ERR_COUNT + 5'(i))
        count_q[i] <= {7'h00, countEvt[i]}; // RQ1 RQ2 RQ3
      else
        count_q[i] <= satInc(count_q[i], countEvt[i]); // RQ1 RQ2 RQ3
    end
  end

  // tenbase sticky controls and broadcast enable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tenCtrl_q <= pecr_pkg::TENBASE_DEFAULT;
    else if (wrEn && mgmtReq.addr == pecr_pkg::ADDR_TENBASE_CTRL)
      tenCtrl_q <= mgmtReq.wdata & pecr_pkg::TENBASE_WR_MASK;
    else if (stickyClear)
      tenCtrl_q <= pecr_pkg::TENBASE_DEFAULT; // RQ6
  end

  // sticky-reset enable ignores software reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      stickyEn_q <= 1'b1; // RQ5
    else if (wrEn && mgmtReq.addr == pecr_pkg::ADDR_TENBASE_CTRL)
      stickyEn_q <= mgmtReq.wdata[pecr_pkg::STICKY_EN_BIT]; // RQ7
  end

  // self-clearing tenbase flags, set wins over the read clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      eofErr_q  <= 1'b0;
      tenDisc_q <= 1'b0;
    end
    else if (softReset)
    begin
      eofErr_q  <= 1'b0;
      tenDisc_q <= 1'b0;
    end
    else
    begin
      eofErr_q  <= lineEvt.eofError ||
                   (eofErr_q && !(rdEn && mgmtReq.addr == pecr_pkg::ADDR_TENBASE_CTRL)); // RQ8
      tenDisc_q <= lineEvt.tenDisconnect ||
                   (tenDisc_q && !(rdEn && mgmtReq.addr == pecr_pkg::ADDR_TENBASE_CTRL)); // RQ8
    end
  end

  // super-sticky media settings held as written, pending until software reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mediaHold_q <= 16'h0000;
    else if (wrEn && mgmtReq.addr == pecr_pkg::ADDR_MEDIA_MODE)
      mediaHold_q <= mgmtReq.wdata & pecr_pkg::MEDIA_HOLD_MASK; // RQ7
  end

  // operating mode in force, loaded from pending value on software reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      modeActive_q <= 6'h00;
    else if (softReset)
      modeActive_q <= mediaHold_q[MODE_BASE +: 6]; // RQ14
  end

  // plain media controls: override and far-end loopback
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mediaPlain_q <= 16'h0000;
    else if (wrEn && mgmtReq.addr == pecr_pkg::ADDR_MEDIA_MODE)
      mediaPlain_q <= mgmtReq.wdata & pecr_pkg::MEDIA_PLAIN_MASK; // RQ16
    else if (softReset)
      mediaPlain_q <= 16'h0000; // RQ16
  end

  // sticky edge rate, reduced power and jumbo settings
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      edgeSticky_q <= 16'h0000;
    else if (wrEn && mgmtReq.addr == pecr_pkg::ADDR_EDGE_JUMBO)
      edgeSticky_q <= mgmtReq.wdata & pecr_pkg::EDGE_STICKY_MASK; // RQ17
    else if (stickyClear)
      edgeSticky_q <= 16'h0000; // RQ6
  end

  // connector loopback, cleared by any reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      edgePlain_q <= 16'h0000;
    else if (wrEn && mgmtReq.addr == pecr_pkg::ADDR_EDGE_JUMBO)
      edgePlain_q <= mgmtReq.wdata & pecr_pkg::EDGE_PLAIN_MASK; // RQ18
    else if (softReset)
      edgePlain_q <= 16'h0000; // RQ18
  end

  // sticky interrupt mask and pin enable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irqMask_q <= 16'h0000;
    else if (wrEn && mgmtReq.addr == pecr_pkg::ADDR_IRQ_MASK)
      irqMask_q <= mgmtReq.wdata;
    else if (stickyClear)
      irqMask_q <= 16'h0000; // RQ6
  end

  // interrupt causes latch regardless of pin enable, a read clears them
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irqCause_q <= 15'h0000;
    else if (softReset)
      irqCause_q <= 15'h0000;
    else if (rdEn && mgmtReq.addr == pecr_pkg::ADDR_IRQ_PENDING)
      irqCause_q <= causeIn; // RQ23 RQ21
    else
      irqCause_q <= irqCause_q | causeIn; // RQ21
  end

  // top pending bit from any masked cause, set wins over the read clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irqTop_q <= 1'b0;
    end
    else if (softReset)
    begin
      irqTop_q <= 1'b0;
    end
    else
    begin
      irqTop_q <= (|(causeIn & irqMask_q[14:0])) || // RQ24
                  (irqTop_q && !(rdEn && mgmtReq.addr == pecr_pkg::ADDR_IRQ_PENDING)); // RQ23
    end
  end

  // read multiplexer
  always_comb
  begin
    readData_d = 16'h0000;
    unique case (mgmtReq.addr)
      pecr_pkg::ADDR_RX_ERR_COUNT:  readData_d = {8'h00, count_q[0]};
      pecr_pkg::ADDR_FALSE_CARRIER: readData_d = {8'h00, count_q[1]};
      pecr_pkg::ADDR_LINK_DISC:     readData_d = {8'h00, count_q[2]};
      pecr_pkg::ADDR_TENBASE_CTRL:
      begin
        readData_d = tenCtrl_q;
        readData_d[pecr_pkg::STICKY_EN_BIT] = stickyEn_q;
        readData_d[pecr_pkg::EOF_ERR_BIT]   = eofErr_q;
        readData_d[pecr_pkg::TEN_DISC_BIT]  = tenDisc_q;
        readData_d[pecr_pkg::TEN_LINK_BIT]  = tenLinkPass; // RQ4
      end
      pecr_pkg::ADDR_MEDIA_MODE:
        readData_d = {mediaHold_q[15:14], modeActive_q, 8'h00} | mediaPlain_q; // RQ15
      pecr_pkg::ADDR_EDGE_JUMBO:    readData_d = edgeSticky_q | edgePlain_q;
      pecr_pkg::ADDR_IRQ_MASK:      readData_d = irqMask_q;
      pecr_pkg::ADDR_IRQ_PENDING:   readData_d = {irqTop_q, irqCause_q};
      default:                      readData_d = 16'h0000;
    endcase
  end

  // read answer registered one cycle after the request
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      readData_q  <= 16'h0000;
      readValid_q <= 1'b0;
    end
    else
    begin
      readValid_q <= rdEn; // RQ10
      if (rdEn)
      begin
        readData_q <= readData_d;
      end
    end
  end

  assign readData  = readData_q;
  assign readValid = readValid_q;

  // control outputs to the rest of the port
  always_comb
  begin
    ctrl                   = '0;
    ctrl.forceLinkHigh     = tenCtrl_q[pecr_pkg::FORCE_LINK_BIT];
    ctrl.jabberDisable     = tenCtrl_q[pecr_pkg::JABBER_BIT];
    ctrl.echoDisable       = tenCtrl_q[pecr_pkg::ECHO_BIT];
    ctrl.heartbeatDisable  = tenCtrl_q[pecr_pkg::HEARTBEAT_BIT];
    ctrl.squelch           = tenCtrl_q[pecr_pkg::SQUELCH_LSB +: 2];
    ctrl.broadcastWrite    = tenCtrl_q[pecr_pkg::BROADCAST_BIT];
    ctrl.macBaseX          = modeActive_q[pecr_pkg::MAC_MODE_BIT - MODE_BASE]; // RQ11
    ctrl.amsPreferCopper   = modeActive_q[pecr_pkg::AMS_PREF_BIT - MODE_BASE];
    ctrl.mediaMode         = modeActive_q[pecr_pkg::MEDIA_MODE_LSB - MODE_BASE +: 3]; // RQ14
    ctrl.amsOverride       = mediaPlain_q[pecr_pkg::AMS_OVERRIDE_LSB +: 2];
    ctrl.farEndLoopback    = mediaPlain_q[pecr_pkg::FAR_LOOP_BIT]; // RQ16
    ctrl.edgeRate          = edgeSticky_q[pecr_pkg::EDGE_RATE_LSB +: 3];
    ctrl.reducedPower      = edgeSticky_q[pecr_pkg::REDUCED_PWR_BIT];
    ctrl.jumboMode         = edgeSticky_q[pecr_pkg::JUMBO_LSB +: 2];
    ctrl.connectorLoopback = edgePlain_q[pecr_pkg::CONN_LOOP_BIT]; // RQ18
  end

  // media selection, link pass and frame limit
  assign media = decodeMedia(ctrl.mediaMode,
                             mediaPlain_q[pecr_pkg::AMS_OVERRIDE_LSB +: 2]); // RQ12 RQ13
  assign tenLinkPass = tenCtrl_q[pecr_pkg::FORCE_LINK_BIT] || lineEvt.tenLinkUp; // RQ4
  assign maxFrameBytes = jumboLimit(edgeSticky_q[pecr_pkg::JUMBO_LSB +: 2]); // RQ17

  // open-drain interrupt pin pulled low while enabled and pending
  assign mgmtIrqPinOut = 1'b0;
  assign mgmtIrqPinOe  = irqMask_q[pecr_pkg::IRQ_PIN_EN_BIT] && irqTop_q; // RQ19 RQ20

endmodule : pecr_bank

`default_nettype wire

// ==== pecr_bank_assertions.sv ====
// concurrent checks on the ports of the extended control register bank
`timescale 1ns/100ps
`default_nettype none
module pecr_bank_checker
(
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        softReset,
  input wire pecr_pkg::pecr_mgmt_req_type mgmtReq,
  input wire pecr_pkg::pecr_line_evt_type lineEvt,
  input wire logic [15:0]                 readData,
  input wire logic                        readValid,
  input wire pecr_pkg::pecr_ctrl_type     ctrl,
  input wire pecr_pkg::pecr_media_type    media,
  input wire logic                        tenLinkPass,
  input wire logic [13:0]                 maxFrameBytes,
  input wire logic                        mgmtIrqPinOut,
  input wire logic                        mgmtIrqPinOe
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // accepted strobes
  logic rdTaken;
  logic wrTaken;
  logic causeOrWr;
  assign rdTaken   = mgmtReq.read & mgmtReq.addressedHere;
  assign wrTaken   = mgmtReq.write & (mgmtReq.addressedHere | ctrl.broadcastWrite);
  assign causeOrWr = (|lineEvt.irqCause) | mgmtReq.write;

  answer_timing_a: assert property (readValid == $past(rdTaken))
    else $error("read answer not one cycle after an accepted read");
  pin_clear_a: assert property (rdTaken && mgmtReq.addr == pecr_pkg::ADDR_IRQ_PENDING &&
    lineEvt.irqCause == 15'h0000 |=> !mgmtIrqPinOe)
    else $error("interrupt pin still asserted after status read");
  pin_rise_a: assert property ($rose(mgmtIrqPinOe) |-> $past(causeOrWr))
    else $error("interrupt pin rose without cause or mask write");
  pin_drive_a: assert property (mgmtIrqPinOut == 1'b0)
    else $error("open drain pin driven high");
  link_pass_a: assert property (tenLinkPass == (ctrl.forceLinkHigh | lineEvt.tenLinkUp))
    else $error("link pass does not follow force or link level");
  frame_len_a: assert property (maxFrameBytes == (ctrl.jumboMode == 2'h1 ?
    pecr_pkg::FRAME_JUMBO_9K : ctrl.jumboMode == 2'h2 ? pecr_pkg::FRAME_JUMBO_12K :
    pecr_pkg::FRAME_NORMAL))
    else $error("packet length limit wrong for jumbo mode");
  far_loop_a: assert property (wrTaken && mgmtReq.addr == pecr_pkg::ADDR_MEDIA_MODE
    |=> ctrl.farEndLoopback == $past(mgmtReq.wdata[3]))
    else $error("far end loopback not taken from write");
  conn_loop_a: assert property (wrTaken && mgmtReq.addr == pecr_pkg::ADDR_EDGE_JUMBO
    |=> ctrl.connectorLoopback == $past(mgmtReq.wdata[0]))
    else $error("connector loopback not taken from write");
  bcast_off_a: assert property (mgmtReq.write && !mgmtReq.addressedHere &&
    !ctrl.broadcastWrite && !softReset && mgmtReq.addr == pecr_pkg::ADDR_EDGE_JUMBO
    |=> $stable(ctrl.connectorLoopback))
    else $error("foreign write applied without broadcast");
  mode_hold_a: assert property (!softReset |=> $stable(ctrl.mediaMode) &&
    $stable(ctrl.macBaseX))
    else $error("operating mode changed without software reset");
  media_auto_a: assert property (ctrl.mediaMode[2] && ctrl.mediaMode[1:0] != 2'h0
    |-> media.autoMediaSelect)
    else $error("auto sense mode not reported");
  media_copper_a: assert property (ctrl.mediaMode == 3'h0 |->
    media.copperAllowed && !media.serdesAllowed)
    else $error("copper only mode allows wrong media");

  // main scenarios reached
  cover property (readValid && readData[15]);
  cover property ($rose(mgmtIrqPinOe));
  cover property (softReset && ctrl.mediaMode == 3'h0);
endmodule : pecr_bank_checker

bind pecr_bank pecr_bank_checker pecr_bank_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .softReset(softReset), .mgmtReq(mgmtReq), .lineEvt(lineEvt), .readData(readData),
  .readValid(readValid), .ctrl(ctrl), .media(media), .tenLinkPass(tenLinkPass),
  .maxFrameBytes(maxFrameBytes), .mgmtIrqPinOut(mgmtIrqPinOut), .mgmtIrqPinOe(mgmtIrqPinOe));
`default_nettype wire

// ==== pecr_mgmt_model.sv ====
// station management controller model issuing decoded register accesses
`timescale 1ns/100ps
`default_nettype none
module pecr_mgmt_model
(
  input  wire logic                        clk,
  input  wire logic [15:0]                 readData,
  input  wire logic                        readValid,
  output var  pecr_pkg::pecr_mgmt_req_type mgmtReq
);
  // idle bus at start
  initial mgmtReq = '0;

  // one write over one rising edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic here);
    @(negedge clk);
    mgmtReq.addr          = a;
    mgmtReq.wdata         = d;
    mgmtReq.addressedHere = here;
    mgmtReq.write         = 1'b1;
    @(negedge clk);
    mgmtReq.write = 1'b0;
    mgmtReq.wdata = ~d; // released data changes
  endtask : wr

  // one read, bounded wait for the answer
  task automatic rd(input logic [4:0] a, input logic here, output logic [15:0] d,
                    output logic ok);
    @(negedge clk);
    mgmtReq.addr          = a;
    mgmtReq.addressedHere = here;
    mgmtReq.read          = 1'b1;
    @(negedge clk);
    mgmtReq.read = 1'b0;
    repeat (3) if (!readValid) @(negedge clk);
    ok = readValid;
    d  = readData;
  endtask : rd
endmodule : pecr_mgmt_model
`default_nettype wire

// ==== pecr_pkg.sv ====
// constants, field layouts and carrier types for the extended control register bank
package pecr_pkg;

  // register addresses in the management space
  localparam logic [4:0] ADDR_RX_ERR_COUNT   = 5'h13;
  localparam logic [4:0] ADDR_FALSE_CARRIER  = 5'h14;
  localparam logic [4:0] ADDR_LINK_DISC      = 5'h15;
  localparam logic [4:0] ADDR_TENBASE_CTRL   = 5'h16;
  localparam logic [4:0] ADDR_MEDIA_MODE     = 5'h17;
  localparam logic [4:0] ADDR_EDGE_JUMBO     = 5'h18;
  localparam logic [4:0] ADDR_IRQ_MASK       = 5'h19;
  localparam logic [4:0] ADDR_IRQ_PENDING    = 5'h1A;

  localparam int         NUM_COUNTERS        = 3;
  localparam logic [7:0] COUNT_MAX           = 8'hFF;

  // tenbase control and status fields
  localparam int          FORCE_LINK_BIT     = 15;
  localparam int          JABBER_BIT         = 14;
  localparam int          ECHO_BIT           = 13;
  localparam int          HEARTBEAT_BIT      = 12;
  localparam int          SQUELCH_LSB        = 10;
  localparam int          STICKY_EN_BIT      = 9;
  localparam int          EOF_ERR_BIT        = 8;
  localparam int          TEN_DISC_BIT       = 7;
  localparam int          TEN_LINK_BIT       = 6;
  localparam int          BROADCAST_BIT      = 0;
  localparam logic [15:0] TENBASE_WR_MASK    = 16'hFC01;
  localparam logic [15:0] TENBASE_DEFAULT    = 16'h3000;

  // media mode control fields
  localparam int          MAC_MODE_BIT       = 12;
  localparam int          AMS_PREF_BIT       = 11;
  localparam int          MEDIA_MODE_LSB     = 8;
  localparam int          AMS_OVERRIDE_LSB   = 6;
  localparam int          FAR_LOOP_BIT       = 3;
  localparam logic [15:0] MEDIA_HOLD_MASK    = 16'hFF00;
  localparam logic [15:0] MEDIA_PLAIN_MASK   = 16'h00C8;

  // edge rate, jumbo and loopback fields
  localparam int          EDGE_RATE_LSB      = 13;
  localparam int          REDUCED_PWR_BIT    = 12;
  localparam int          JUMBO_LSB          = 4;
  localparam int          CONN_LOOP_BIT      = 0;
  localparam logic [15:0] EDGE_STICKY_MASK   = 16'hF030;
  localparam logic [15:0] EDGE_PLAIN_MASK    = 16'h0001;

  // interrupt fields
  localparam int          IRQ_PIN_EN_BIT     = 15;
  localparam int          IRQ_TOP_BIT        = 15;
  localparam logic [14:0] IRQ_CAUSE_MASK     = 15'h7FBF;

  // packet length limits in bytes
  localparam logic [13:0] FRAME_NORMAL       = 14'h0600;
  localparam logic [13:0] FRAME_JUMBO_9K     = 14'h2400;
  localparam logic [13:0] FRAME_JUMBO_12K    = 14'h3000;

  typedef enum logic [1:0] {JUMBO_NORMAL, JUMBO_9K, JUMBO_12K, JUMBO_RSVD} pecr_jumbo_type;

  // one decoded management frame aimed at this port's register space
  typedef struct packed {
    logic        write;
    logic        read;
    logic        addressedHere;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pecr_mgmt_req_type;

  // events and levels reported by the line side
  typedef struct packed {
    logic        rxError;
    logic        falseCarrier;
    logic        linkDisconnect;
    logic        eofError;
    logic        tenDisconnect;
    logic        tenLinkUp;
    logic [14:0] irqCause;
  } pecr_line_evt_type;

  // settings driven into the rest of the port
  typedef struct packed {
    logic        forceLinkHigh;
    logic        jabberDisable;
    logic        echoDisable;
    logic        heartbeatDisable;
    logic [1:0]  squelch;
    logic        broadcastWrite;
    logic        macBaseX;
    logic        amsPreferCopper;
    logic [2:0]  mediaMode;
    logic [1:0]  amsOverride;
    logic        farEndLoopback;
    logic [2:0]  edgeRate;
    logic        reducedPower;
    logic [1:0]  jumboMode;
    logic        connectorLoopback;
  } pecr_ctrl_type;

  // media selection derived from mode and override
  typedef struct packed {
    logic copperAllowed;
    logic serdesAllowed;
    logic autoMediaSelect;
    logic modeReserved;
  } pecr_media_type;

endpackage : pecr_pkg

// ==== pecr_tb.sv ====
// self-checking bench for the extended control register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {logic wr; logic [4:0] a; logic [15:0] d; logic [15:0] e;} pecr_row_type;

  logic                        clk = 1'b0;
  logic                        sys_rst;
  logic                        softReset;
  pecr_pkg::pecr_mgmt_req_type mgmtReq;
  pecr_pkg::pecr_line_evt_type lineEvt;
  logic [15:0]                 readData;
  logic                        readValid;
  pecr_pkg::pecr_ctrl_type     ctrl;
  pecr_pkg::pecr_media_type    media;
  logic                        tenLinkPass;
  logic [13:0]                 maxFrameBytes;
  logic                        mgmtIrqPinOut;
  logic                        mgmtIrqPinOe;
  logic [15:0]                 rdData;
  logic                        rdOk;
  int                          failures = 0;
  int                          checks = 0;
  int                          cycles = 0;
  pecr_row_type                rows [0:17];
  logic [15:0]                 frame [0:3] = '{16'h0600, 16'h2400, 16'h3000, 16'h0600};

  // clock and cycle ceiling
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      failures++;
      test_done();
    end
  end

  pecr_bank pecr_bank_inst (.clk(clk), .sys_rst(sys_rst), .softReset(softReset),
    .mgmtReq(mgmtReq), .lineEvt(lineEvt), .readData(readData), .readValid(readValid),
    .ctrl(ctrl), .media(media), .tenLinkPass(tenLinkPass), .maxFrameBytes(maxFrameBytes),
    .mgmtIrqPinOut(mgmtIrqPinOut), .mgmtIrqPinOe(mgmtIrqPinOe));
  pecr_mgmt_model pecr_mgmt_model_inst (.clk(clk), .readData(readData),
    .readValid(readValid), .mgmtReq(mgmtReq));

  // verdict and end of run
  task automatic test_done;
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // compare a register word
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  // compare a single flag
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  // addressed read and compare of the answer
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    pecr_mgmt_model_inst.rd(a, 1'b1, rdData, rdOk);
    chk_bit(rdOk, 1'b1);
    chk_word(rdData, e);
  endtask : rdchk

  // line events held high for n cycles
  task automatic pulse(input logic [20:0] e, input int n);
    @(negedge clk);
    lineEvt = pecr_pkg::pecr_line_evt_type'(e);
    repeat (n) @(negedge clk);
    lineEvt = '0;
  endtask : pulse

  // one-cycle software reset
  task automatic soft_rst;
    @(negedge clk);
    softReset = 1'b1;
    @(negedge clk);
    softReset = 1'b0;
  endtask : soft_rst

  // main sequence
  initial
  begin
    rows = '{'{1'b0, 5'h13, 16'h0000, 16'h0000}, '{1'b0, 5'h14, 16'h0000, 16'h0000},
             '{1'b0, 5'h15, 16'h0000, 16'h0000}, '{1'b0, 5'h16, 16'h0000, 16'h3200},
             '{1'b0, 5'h17, 16'h0000, 16'h0000}, '{1'b0, 5'h18, 16'h0000, 16'h0000},
             '{1'b0, 5'h19, 16'h0000, 16'h0000}, '{1'b0, 5'h1A, 16'h0000, 16'h0000},
             '{1'b1, 5'h16, 16'hFFFF, 16'hFE41}, '{1'b1, 5'h16, 16'h3200, 16'h3200},
             '{1'b1, 5'h17, 16'h00C8, 16'h00C8}, '{1'b1, 5'h17, 16'h1508, 16'h0008},
             '{1'b1, 5'h18, 16'hFFFF, 16'hF031}, '{1'b1, 5'h18, 16'h0000, 16'h0000},
             '{1'b1, 5'h19, 16'hFFFF, 16'hFFFF}, '{1'b1, 5'h19, 16'h0000, 16'h0000},
             '{1'b1, 5'h13, 16'hFFFF, 16'h0000}, '{1'b1, 5'h1F, 16'hFFFF, 16'h0000}};
    sys_rst   = 1'b1;
    softReset = 1'b0;
    lineEvt   = '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    // reset values, then writes with readback
    foreach (rows[i])
    begin
      if (rows[i].wr)
        pecr_mgmt_model_inst.wr(rows[i].a, rows[i].d, 1'b1);
      rdchk(rows[i].a, rows[i].e);
    end
    // counters saturate and clear on read
    for (int k = 0; k < 3; k++)
    begin
      pulse(21'h100000 >> k, 300);
      rdchk(5'(pecr_pkg::ADDR_RX_ERR_COUNT + 5'(k)), 16'h00FF);
      rdchk(5'(pecr_pkg::ADDR_RX_ERR_COUNT + 5'(k)), 16'h0000);
    end
    // end-of-frame and disconnect flags
    pulse(21'h030000, 1);
    rdchk(pecr_pkg::ADDR_TENBASE_CTRL, 16'h3380);
    rdchk(pecr_pkg::ADDR_TENBASE_CTRL, 16'h3200);
    // broadcast writes
    pecr_mgmt_model_inst.wr(pecr_pkg::ADDR_EDGE_JUMBO, 16'h0001, 1'b0);
    rdchk(pecr_pkg::ADDR_EDGE_JUMBO, 16'h0000);
    pecr_mgmt_model_inst.wr(pecr_pkg::ADDR_TENBASE_CTRL, 16'h3201, 1'b1);
    pecr_mgmt_model_inst.wr(pecr_pkg::ADDR_EDGE_JUMBO, 16'h0001, 1'b0);
    rdchk(pecr_pkg::ADDR_EDGE_JUMBO, 16'h0001);
    pecr_mgmt_model_inst.rd(pecr_pkg::ADDR_EDGE_JUMBO, 1'b0, rdData, rdOk);
    chk_bit(rdOk, 1'b0);
    pecr_mgmt_model_inst.wr(pecr_pkg::ADDR_TENBASE_CTRL, 16'h3200, 1'b1);
    // every jumbo code
    for (int j = 0; j < 4; j++)
    begin
      pecr_mgmt_model_inst.wr(pecr_pkg::ADDR_EDGE_JUMBO, 16'(j << 4), 1'b1);
      chk_word({2'h0, maxFrameBytes}, frame[j]);
    end
    // interrupt pin and status
    rdchk(pecr_pkg::ADDR_IRQ_PENDING, 16'h0000);
    pecr_mgmt_model_inst.wr(pecr_pkg::ADDR_IRQ_MASK, 16'h0001, 1'b1);
    pulse(21'h000001, 1);
    chk_bit(mgmtIrqPinOe, 1'b0);
    rdchk(pecr_pkg::ADDR_IRQ_PENDING, 16'h8001);
    pecr_mgmt_model_inst.wr(pecr_pkg::ADDR_IRQ_MASK, 16'h8001, 1'b1);
    pulse(21'h000001, 1);
    chk_bit(mgmtIrqPinOe, 1'b1);
    rdchk(pecr_pkg::ADDR_IRQ_PENDING, 16'h8001);
    chk_bit(mgmtIrqPinOe, 1'b0);
    pulse(21'h000002, 1);
    chk_bit(mgmtIrqPinOe, 1'b0);
    rdchk(pecr_pkg::ADDR_IRQ_PENDING, 16'h0002);
    // software reset
    pecr_mgmt_model_inst.wr(pecr_pkg::ADDR_TENBASE_CTRL, 16'h4200, 1'b1);
    soft_rst();
    rdchk(pecr_pkg::ADDR_TENBASE_CTRL, 16'h4200);
    rdchk(pecr_pkg::ADDR_MEDIA_MODE, 16'h1500);
    chk_word({11'h000, ctrl.macBaseX, media}, 16'h001E);
    pecr_mgmt_model_inst.wr(pecr_pkg::ADDR_TENBASE_CTRL, 16'h4000, 1'b1);
    soft_rst();
    rdchk(pecr_pkg::ADDR_TENBASE_CTRL, 16'h3000);
    rdchk(pecr_pkg::ADDR_MEDIA_MODE, 16'h1500);
    test_done();
  end
endmodule : tb
`default_nettype wire
